// file: inc/qdsl_pkg.sv
// shared constants and carrier types of the quad converter serial load block
package qdsl_pkg;

    // serial word layout
    localparam int WORD_BITS = 16;
    localparam int DATA_W = 12;
    localparam int NUM_CONV = 4;
    localparam int SEL_W = 2;
    localparam int ADDR_W = 2;
    localparam int CNT_W = 5;
    localparam logic [4:0] CNT_LAST = 5'h0f;
    localparam logic [4:0] CNT_DONE = 5'h10;
    localparam logic [4:0] CNT_ONE = 5'h01;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_LAST = 8'h08;
    localparam logic [7:0] ADDR_LOADS = 8'h0c;
    localparam logic [7:0] ADDR_IN_BASE = 8'h10;
    localparam logic [7:0] ADDR_CONV_BASE = 8'h20;
    localparam logic [7:0] ADDR_BLK_MASK = 8'hf3;

    // control bits
    localparam int CTRL_ACCEPT = 0;
    localparam int CTRL_LOAD = 1;
    localparam int CTRL_CLEAR = 2;
    localparam logic CTRL_ACCEPT_RST = 1'b1;

    // status fields
    localparam int ST_ACC_LSB = 0;
    localparam int ST_REJ_LSB = 8;
    localparam int ST_STRAP_LSB = 16;
    localparam int ST_FRAME_BIT = 18;
    localparam int ST_LOAD_BIT = 19;
    localparam int ST_CLEAR_BIT = 20;

    localparam logic [7:0] CNT8_ONE = 8'h01;

    // one serial word, most significant field first
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [ADDR_W-1:0] addr;
        logic [SEL_W-1:0] sel;
    } qdsl_word_type;

    typedef struct packed {
        logic [WORD_BITS-1:0] shreg;
        qdsl_word_type word;
        logic tgl;
    } qdsl_link_st_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } qdsl_apb_req_type;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } qdsl_apb_rsp_type;

    typedef struct packed {
        logic tgl_s1;
        logic tgl_s2;
        logic tgl_s3;
        logic [1:0] strap_s1;
        logic [1:0] strap_s2;
        logic ld_s1;
        logic ld_s2;
        logic clr_s1;
        logic clr_s2;
        logic frm_s1;
        logic frm_s2;
        logic [NUM_CONV-1:0][DATA_W-1:0] in_latch;
        logic [NUM_CONV-1:0][DATA_W-1:0] conv;
        logic accept_en;
        logic soft_load;
        logic soft_clear;
        logic [7:0] acc_cnt;
        logic [7:0] rej_cnt;
        logic [7:0] load_cnt;
        qdsl_word_type last_word;
        qdsl_apb_rsp_type rsp;
    } qdsl_sys_st_type;

endpackage

// file: design/qdsl_link_shift.sv
// link-side input shift register, clocked on falling shift clock edges
`timescale 1ns/1ps
`default_nettype none

module qdsl_link_shift (
    // link pins
    input wire logic shift_clock_i,
    input wire logic arst_n_i,
    input wire logic frame_sync_n_i,
    input wire logic serial_in_i,
    // chain and word out
    output logic serial_chain_out_o,
    output qdsl_pkg::qdsl_word_type word_o,
    output logic word_tgl_o
);

    qdsl_pkg::qdsl_link_st_type s_r;
    qdsl_pkg::qdsl_link_st_type s_nxt;
    logic [qdsl_pkg::CNT_W-1:0] cnt_r;
    logic [qdsl_pkg::CNT_W-1:0] cnt_nxt;
    logic [qdsl_pkg::WORD_BITS-1:0] shifted;
    logic cnt_clr_n;

    assign shifted = {s_r.shreg[qdsl_pkg::WORD_BITS-2:0], serial_in_i};
    // the link clock stops between frames, so the frame itself must clear the count
    assign cnt_clr_n = arst_n_i & ~frame_sync_n_i;

    always_comb begin
        s_nxt = s_r;
        cnt_nxt = cnt_r;
        // RQ2: shift only while framed
        if (!frame_sync_n_i) begin
            // RQ3: sample data, msb first
            // RQ16: msb enters first
            s_nxt.shreg = shifted;
            // RQ4: sixteenth edge hands word over
            // RQ5: decode only full words
            if (cnt_r == qdsl_pkg::CNT_LAST) begin
                s_nxt.word = shifted;
                s_nxt.tgl = ~s_r.tgl;
            end
            if (cnt_r != qdsl_pkg::CNT_DONE) begin
                cnt_nxt = cnt_r + qdsl_pkg::CNT_ONE;
            end
        end
    end

    always_ff @(negedge shift_clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_ff @(negedge shift_clock_i or negedge cnt_clr_n) begin
        if (!cnt_clr_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // RQ10: chain output ignores address
    // RQ15: chain output is register end
    assign serial_chain_out_o = s_r.shreg[qdsl_pkg::WORD_BITS-1];
    assign word_o = s_r.word;
    assign word_tgl_o = s_r.tgl;

    default clocking link_cb @(negedge shift_clock_i);
    endclocking
    default disable iff (!arst_n_i);

    shift_sample_a: assert property (!frame_sync_n_i |=> s_r.shreg[0] == $past(serial_in_i)) // RQ3
        else $error("serial bit not sampled");
    chain_tail_a: assert property (!frame_sync_n_i |=> serial_chain_out_o == $past(s_r.shreg[14])) // RQ15
        else $error("chain output not shift end");
    word_take_a: assert property ((!frame_sync_n_i && cnt_r == qdsl_pkg::CNT_LAST)
        |=> (word_tgl_o != $past(word_tgl_o)) && (word_o == $past(shifted))) // RQ4
        else $error("word not handed over on sixteenth edge");
    word_len_a: assert property ((word_tgl_o != $past(word_tgl_o)) |-> $past(cnt_r) == qdsl_pkg::CNT_LAST) // RQ5
        else $error("word handed over before sixteen bits");

endmodule

`default_nettype wire

// file: design/qdsl_top.sv
// quad converter serial load interface: input and converter latches, apb view
//
// Function
// RQ1: load strobe low copies every input latch into its converter latch together.
// RQ2: frame sync is active-low level; while low the shift register is enabled.
// RQ3: serial data is sampled on each falling shift clock edge while framed.
// RQ4: sixteenth falling edge moves the data field into the selected input latch.
// RQ5: words are exactly sixteen bits; decoding waits for all of them.
// RQ6: two lowest word bits pick one of four input latches.
// RQ7: next two bits must equal the strap pins, high pin to high bit.
// RQ8: upper twelve word bits are the code written to the latch.
// RQ9: address mismatch discards the word, leaving all input latches unchanged.
// RQ10: shifted bits reach the chain output whether or not the address matched.
// RQ11: the board pulls the shift clock low so it idles low.
// RQ12: clear low forces every converter latch to zero.
// RQ13: clear leaves input latches alone so a later load restores them.
// RQ14: select 00 is converter A, 01 B, 10 C, 11 D.
// RQ15: chain output is the end of the shift register, for daisy chains.
// RQ16: words go most significant bit first, select low bit last.
// RQ17: host raises frame sync after sixteen edges and holds load high meanwhile.
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module qdsl_top #(
    parameter int NUM_CONV = qdsl_pkg::NUM_CONV,
    parameter int DATA_W = qdsl_pkg::DATA_W
) (
    // system clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // serial link
    input wire logic shift_clock_i,
    input wire logic frame_sync_n_i,
    input wire logic serial_in_i,
    output logic serial_chain_out_o,
    // strap and latch control pins
    input wire logic strap_addr_lo_i,
    input wire logic strap_addr_hi_i,
    input wire logic load_all_strobe_n_i,
    input wire logic latch_zero_n_i,
    // converter latch contents
    output logic [qdsl_pkg::NUM_CONV-1:0][qdsl_pkg::DATA_W-1:0] conv_code_o,
    // apb slave
    input wire qdsl_pkg::qdsl_apb_req_type apb_req_i,
    output qdsl_pkg::qdsl_apb_rsp_type apb_rsp_o
);

    // the select field is two bits wide, so only four twelve-bit latches fit
    if (NUM_CONV != qdsl_pkg::NUM_CONV || DATA_W != qdsl_pkg::DATA_W) begin : g_check
        $error("qdsl_top supports only four twelve-bit converters");
    end

    qdsl_pkg::qdsl_sys_st_type s_r;
    qdsl_pkg::qdsl_sys_st_type s_nxt;
    qdsl_pkg::qdsl_word_type link_word;
    logic link_tgl;
    logic new_word;
    logic addr_ok;
    logic setup;
    logic access;
    logic ctrl_wr;

    qdsl_link_shift u_link (
        .shift_clock_i(shift_clock_i),
        .arst_n_i(arst_n_i),
        .frame_sync_n_i(frame_sync_n_i),
        .serial_in_i(serial_in_i),
        .serial_chain_out_o(serial_chain_out_o),
        .word_o(link_word),
        .word_tgl_o(link_tgl)
    );

    // register decode
    function automatic logic is_mapped(input logic [7:0] a);
        logic ok;
        ok = 1'b0;
        if (a == qdsl_pkg::ADDR_CTRL) begin
            ok = 1'b1;
        end else if (a == qdsl_pkg::ADDR_STATUS) begin
            ok = 1'b1;
        end else if (a == qdsl_pkg::ADDR_LAST) begin
            ok = 1'b1;
        end else if (a == qdsl_pkg::ADDR_LOADS) begin
            ok = 1'b1;
        end else if ((a & qdsl_pkg::ADDR_BLK_MASK) == qdsl_pkg::ADDR_IN_BASE) begin
            ok = 1'b1;
        end else if ((a & qdsl_pkg::ADDR_BLK_MASK) == qdsl_pkg::ADDR_CONV_BASE) begin
            ok = 1'b1;
        end
        return ok;
    endfunction

    function automatic logic [31:0] rd_data(input logic [7:0] a, input qdsl_pkg::qdsl_sys_st_type st);
        logic [31:0] d;
        d = '0;
        if (a == qdsl_pkg::ADDR_CTRL) begin
            d[qdsl_pkg::CTRL_ACCEPT] = st.accept_en;
        end else if (a == qdsl_pkg::ADDR_STATUS) begin
            d[qdsl_pkg::ST_ACC_LSB +: 8] = st.acc_cnt;
            d[qdsl_pkg::ST_REJ_LSB +: 8] = st.rej_cnt;
            d[qdsl_pkg::ST_STRAP_LSB +: 2] = st.strap_s2;
            d[qdsl_pkg::ST_FRAME_BIT] = ~st.frm_s2;
            d[qdsl_pkg::ST_LOAD_BIT] = ~st.ld_s2;
            d[qdsl_pkg::ST_CLEAR_BIT] = ~st.clr_s2;
        end else if (a == qdsl_pkg::ADDR_LAST) begin
            d[15:0] = st.last_word;
        end else if (a == qdsl_pkg::ADDR_LOADS) begin
            d[7:0] = st.load_cnt;
        end else if ((a & qdsl_pkg::ADDR_BLK_MASK) == qdsl_pkg::ADDR_IN_BASE) begin
            d[11:0] = st.in_latch[a[3:2]];
        end else if ((a & qdsl_pkg::ADDR_BLK_MASK) == qdsl_pkg::ADDR_CONV_BASE) begin
            d[11:0] = st.conv[a[3:2]];
        end
        return d;
    endfunction

    // the word is only read once its toggle has crossed, so it has long been stable
    assign new_word = s_r.tgl_s2 ^ s_r.tgl_s3;
    // RQ7: address field against straps
    assign addr_ok = (link_word.addr == s_r.strap_s2);
    assign setup = apb_req_i.psel & ~apb_req_i.penable;
    assign access = apb_req_i.psel & apb_req_i.penable & s_r.rsp.pready;
    assign ctrl_wr = access & apb_req_i.pwrite & (apb_req_i.paddr == qdsl_pkg::ADDR_CTRL);

    always_comb begin
        s_nxt = s_r;
        // synchronisers: the first stage feeds only the second
        s_nxt.tgl_s1 = link_tgl;
        s_nxt.tgl_s2 = s_r.tgl_s1;
        s_nxt.tgl_s3 = s_r.tgl_s2;
        s_nxt.strap_s1 = {strap_addr_hi_i, strap_addr_lo_i};
        s_nxt.strap_s2 = s_r.strap_s1;
        s_nxt.ld_s1 = load_all_strobe_n_i;
        s_nxt.ld_s2 = s_r.ld_s1;
        s_nxt.clr_s1 = latch_zero_n_i;
        s_nxt.clr_s2 = s_r.clr_s1;
        s_nxt.frm_s1 = frame_sync_n_i;
        s_nxt.frm_s2 = s_r.frm_s1;
        s_nxt.soft_load = 1'b0;
        s_nxt.soft_clear = 1'b0;
        s_nxt.rsp.pready = 1'b0;
        s_nxt.rsp.pslverr = 1'b0;

        // word intake
        if (new_word) begin
            s_nxt.last_word = link_word;
            // RQ9: mismatch leaves latches untouched
            if (s_r.accept_en && addr_ok) begin
                // RQ6: select picks the latch
                // RQ14: 00 is A through 11 is D
                // RQ8: upper twelve bits are the code
                s_nxt.in_latch[link_word.sel] = link_word.data;
                s_nxt.acc_cnt = s_r.acc_cnt + qdsl_pkg::CNT8_ONE;
            end else begin
                s_nxt.rej_cnt = s_r.rej_cnt + qdsl_pkg::CNT8_ONE;
            end
        end

        // converter latches; clear wins over load
        // RQ12: clear forces zero
        // RQ13: input latches not touched here
        if (!s_r.clr_s2 || s_r.soft_clear) begin
            s_nxt.conv = '0;
        end else if (!s_r.ld_s2 || s_r.soft_load) begin
            // RQ1: all latches copied together
            s_nxt.conv = s_r.in_latch;
            s_nxt.load_cnt = s_r.load_cnt + qdsl_pkg::CNT8_ONE;
        end

        // apb: answer prepared in setup, given in the first access cycle
        if (setup) begin
            s_nxt.rsp.pready = 1'b1;
            if (is_mapped(apb_req_i.paddr)) begin
                s_nxt.rsp.prdata = apb_req_i.pwrite ? 32'h0000_0000 : rd_data(apb_req_i.paddr, s_r);
            end else begin
                s_nxt.rsp.pslverr = 1'b1;
                s_nxt.rsp.prdata = 32'h0000_0000;
            end
        end
        if (ctrl_wr) begin
            s_nxt.accept_en = apb_req_i.pwdata[qdsl_pkg::CTRL_ACCEPT];
            s_nxt.soft_load = apb_req_i.pwdata[qdsl_pkg::CTRL_LOAD];
            s_nxt.soft_clear = apb_req_i.pwdata[qdsl_pkg::CTRL_CLEAR];
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_r <= '0;
            // strobes idle high; the synchronisers start from that level
            s_r.ld_s1 <= 1'b1;
            s_r.ld_s2 <= 1'b1;
            s_r.clr_s1 <= 1'b1;
            s_r.clr_s2 <= 1'b1;
            s_r.frm_s1 <= 1'b1;
            s_r.frm_s2 <= 1'b1;
            s_r.accept_en <= qdsl_pkg::CTRL_ACCEPT_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign conv_code_o = s_r.conv;
    assign apb_rsp_o = s_r.rsp;

    default clocking sys_cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);

    load_copy_a: assert property ((!s_r.ld_s2 && s_r.clr_s2 && !s_r.soft_clear)
        |=> s_r.conv == $past(s_r.in_latch)) // RQ1
        else $error("load strobe did not copy input latches");
    clear_zero_a: assert property (!s_r.clr_s2 |=> s_r.conv == '0) // RQ12
        else $error("clear did not zero converter latches");
    clear_keep_a: assert property ((!s_r.clr_s2 && !new_word) |=> $stable(s_r.in_latch)) // RQ13
        else $error("clear disturbed input latches");
    addr_miss_a: assert property ((new_word && !addr_ok) |=> $stable(s_r.in_latch)) // RQ9
        else $error("mismatched word changed a latch");
    latch_write_a: assert property ((new_word && addr_ok && s_r.accept_en)
        |=> s_r.in_latch[$past(link_word.sel)] == $past(link_word.data)) // RQ8
        else $error("accepted word not written");
    sel_a_write_a: assert property ((new_word && addr_ok && s_r.accept_en && link_word.sel == 2'h0)
        |=> s_r.in_latch[0] == $past(link_word.data) && s_r.in_latch[3:1] == $past(s_r.in_latch[3:1])) // RQ14
        else $error("select 00 did not address converter A only");
    apb_answer_a: assert property (setup |=> apb_rsp_o.pready ##1 !apb_rsp_o.pready)
        else $error("apb answer not one cycle after setup");
    unmapped_err_a: assert property ((setup && !is_mapped(apb_req_i.paddr))
        |=> apb_rsp_o.pslverr && apb_rsp_o.prdata == 32'h0000_0000)
        else $error("unmapped access not flagged");

endmodule

`default_nettype wire

// file: testbench/qdsl_host_model.sv
// host side model: frames and shifts serial words into the block
`timescale 1ns/1ps
`default_nettype none

module qdsl_host_model (
    // link pins
    output logic shift_clock_o,
    output logic frame_sync_n_o,
    output logic serial_out_o,
    // chain output coming back from the block
    input wire logic chain_i
);
    logic [15:0] chain_seen;

    initial begin
        shift_clock_o = 1'b0;
        frame_sync_n_o = 1'b1;
        serial_out_o = 1'b0;
        chain_seen = 16'h0;
    end

    task automatic send(input logic [31:0] bits, input int n);
        frame_sync_n_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            // chain output is settled between falling edges: bit i-16 stands here
            #1 if (i >= 16) chain_seen = {chain_seen[14:0], chain_i};
            shift_clock_o = 1'b1;
            serial_out_o = bits[31-i];
            #3 shift_clock_o = 1'b0;
            #2;
        end
        frame_sync_n_o = 1'b1;
        // released line flips so a stale bit can never pass as valid
        serial_out_o = ~serial_out_o;
    endtask
endmodule

`default_nettype wire

// file: testbench/tb_qdsl_top.sv
// self-checking bench of the quad converter serial load block
`timescale 1ns/1ps
`default_nettype none

module tb_qdsl_top;
    logic clk_sys_i;
    logic arst_n_i;
    logic strap_hi;
    logic strap_lo;
    logic load_n;
    logic zero_n;
    logic sclk;
    logic frame_n;
    logic sdata;
    logic chain;
    logic [3:0][11:0] conv;
    qdsl_pkg::qdsl_apb_req_type apb_req;
    qdsl_pkg::qdsl_apb_rsp_type apb_rsp;
    int fails;
    int comparisons;
    logic [31:0] rd;
    logic err;
    logic [11:0] codes [4];

    qdsl_top DUT (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .shift_clock_i(sclk),
        .frame_sync_n_i(frame_n),
        .serial_in_i(sdata),
        .serial_chain_out_o(chain),
        .strap_addr_lo_i(strap_lo),
        .strap_addr_hi_i(strap_hi),
        .load_all_strobe_n_i(load_n),
        .latch_zero_n_i(zero_n),
        .conv_code_o(conv),
        .apb_req_i(apb_req),
        .apb_rsp_o(apb_rsp)
    );

    qdsl_host_model host (
        .shift_clock_o(sclk),
        .frame_sync_n_o(frame_n),
        .serial_out_o(sdata),
        .chain_i(chain)
    );

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge clk_sys_i);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 16);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        if (n >= 16) check("pready", 32'h1, 32'h0);
        apb_req <= '0;
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(name, exp, rd);
    endtask

    // six cycles cover the latch update and the minimum word spacing
    task automatic send_word(input logic [15:0] w);
        host.send({w, 16'h0}, 16);
        repeat (6) @(posedge clk_sys_i);
    endtask

    task automatic conv_chk(input logic zero);
        for (int i = 0; i < 4; i++) begin
            check("conv_code", zero ? 32'h0 : {20'h0, codes[i]}, {20'h0, conv[i]});
        end
    endtask

    task automatic pins(input logic ld_n, input logic zr_n);
        load_n <= ld_n;
        zero_n <= zr_n;
        repeat (5) @(posedge clk_sys_i);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    // the tests need under 2000 cycles; this allows ten times that
    initial begin
        #2000000;
        fails++;
        report_and_stop();
    end

    initial begin
        arst_n_i = 1'b0;
        load_n = 1'b1;
        zero_n = 1'b1;
        strap_hi = 1'b1;
        strap_lo = 1'b0;
        apb_req = '0;
        fails = 0;
        comparisons = 0;
        codes = '{12'h8a5, 12'h35c, 12'hf01, 12'h7fe};
        repeat (4) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        repeat (12) @(posedge clk_sys_i);
        rd_chk("ctrl", 8'h00, 32'h1);
        rd_chk("conv_a", 8'h20, 32'h0);
        apb(1'b0, 8'h30, 32'h0);
        check("unmapped_err", 32'h1, {31'h0, err});
        $display("test reset done");

        for (int i = 0; i < 4; i++) begin
            send_word({codes[i], 2'b10, 2'(i)});
            rd_chk("in_latch", 8'h10 + 8'(4 * i), {20'h0, codes[i]});
            check("conv_held", 32'h0, {20'h0, conv[i]});
        end
        $display("test channel writes done");

        send_word({12'h0ff, 2'b01, 2'b00});
        rd_chk("in_latch_a", 8'h10, {20'h0, codes[0]});
        rd_chk("last", 8'h08, 32'h0000_0ff4);
        rd_chk("status", 8'h04, 32'h0002_0104);
        $display("test address mismatch done");

        host.send({12'h9c6, 2'b11, 2'b01, 12'h123, 2'b10, 2'b11}, 32);
        repeat (6) @(posedge clk_sys_i);
        check("chain", 32'h0000_9c6d, {16'h0, host.chain_seen});
        rd_chk("in_latch_d", 8'h1c, {20'h0, codes[3]});
        host.send({12'h456, 2'b10, 2'b00, 16'h0}, 8);
        repeat (6) @(posedge clk_sys_i);
        rd_chk("in_latch_a", 8'h10, {20'h0, codes[0]});
        $display("test chain and abort done");

        apb(1'b1, 8'h00, 32'h0);
        rd_chk("ctrl", 8'h00, 32'h0);
        send_word({12'h001, 2'b10, 2'b01});
        rd_chk("in_latch_b", 8'h14, {20'h0, codes[1]});
        apb(1'b1, 8'h00, 32'h1);
        rd_chk("status", 8'h04, 32'h0002_0304);
        $display("test accept enable done");

        pins(1'b0, 1'b1);
        pins(1'b1, 1'b1);
        conv_chk(1'b0);
        rd_chk("conv_c", 8'h28, {20'h0, codes[2]});
        pins(1'b0, 1'b0);
        conv_chk(1'b1);
        pins(1'b1, 1'b0);
        pins(1'b1, 1'b1);
        conv_chk(1'b1);
        rd_chk("in_latch_c", 8'h18, {20'h0, codes[2]});
        pins(1'b0, 1'b1);
        pins(1'b1, 1'b1);
        conv_chk(1'b0);
        apb(1'b1, 8'h00, 32'h5);
        repeat (3) @(posedge clk_sys_i);
        conv_chk(1'b1);
        apb(1'b1, 8'h00, 32'h3);
        repeat (3) @(posedge clk_sys_i);
        conv_chk(1'b0);
        rd_chk("loads", 8'h0c, 32'h0000_000b);
        $display("test load and clear done");
        report_and_stop();
    end
endmodule

`default_nettype wire
